// ---- core/humidity_temp_code_converter.sv ----
`timescale 1ns/1ps
// Behaviour
// - reset gives 12-bit humidity, 14-bit temperature
// - two bytes per word, high byte first
// - legacy scales by the resolutions loaded on res_load_i, native by 2^16
module humidity_temp_code_converter (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic byte_valid_i,
    input wire logic [7:0] byte_i,
    input wire logic byte_is_temp_i,
    input wire logic legacy_i,
    input wire logic over_ice_i,
    input wire logic res_load_i,
    input wire logic [4:0] rh_res_i,
    input wire logic [4:0] t_res_i,
    output logic [4:0] rh_res_o,
    output logic [4:0] t_res_o,
    output conv_pkg::conv_res_t result_o,
    output logic result_valid_o
);
    // byte assembly and resolution state
    logic [7:0] high_byte, next_high_byte;
    logic have_high, next_have_high;
    logic [15:0] rh_code, next_rh_code;
    logic have_rh, next_have_rh;
    logic [4:0] rh_res, next_rh_res;
    logic [4:0] t_res, next_t_res;
    conv_pkg::conv_res_t result, next_result;
    logic result_valid, next_result_valid;

    // ice factor: exp(bw t/(lw+t) - bi t/(li+t)); approximated by second-order
    // expansion in units of 1e-4, a trade of accuracy against a real exp unit
    function automatic logic signed [31:0] ice_fix(input logic signed [31:0] rh_c,
                                                    input logic signed [31:0] t_c);
        logic signed [63:0] a;
        logic signed [63:0] b;
        logic signed [63:0] x;
        a = 64'(conv_pkg::BETA_W_CENTI) * t_c * 100 / (64'(conv_pkg::LAMBDA_W_CENTI) + t_c);
        b = 64'(conv_pkg::BETA_I_CENTI) * t_c * 100 / (64'(conv_pkg::LAMBDA_I_CENTI) + t_c);
        x = a - b; // exponent in units of 1e-4
        // exp(x) ~ 1 + x + x^2/2, all terms kept in 1e-4; the square needs a
        // second 1e-4 scale and the half, hence the 20000
        x = 64'sd10000 + x + (x * x) / 64'sd20000;
        return 32'((64'(rh_c) * x + 64'sd5000) / 64'sd10000);
    endfunction : ice_fix

    // true on the edge that takes the low byte of a temperature word
    function automatic logic closes_temp(input logic vld, input logic hi, input logic tmp);
        return vld && hi && tmp;
    endfunction : closes_temp

    // scale code by centi factor over 2^shift with round to nearest
    function automatic logic signed [31:0] scale(input logic [15:0] code, input int factor,
                                                 input int offs, input logic [4:0] sh);
        logic [47:0] p;
        p = 48'(code) * 48'(factor) + (48'h1 << (sh - 5'h01));
        return 32'(offs) + 32'(p >> sh);
    endfunction : scale

    // next-state logic
    always_comb
    begin
        logic [15:0] word;
        logic [4:0] sh;
        word = '0;
        sh = 5'h10;
        next_high_byte = high_byte;
        next_have_high = have_high;
        next_rh_code = rh_code;
        next_have_rh = have_rh;
        next_rh_res = rh_res;
        next_t_res = t_res;
        next_result = result;
        next_result_valid = 1'b0;
        if (res_load_i)
        begin
            next_rh_res = rh_res_i;
            next_t_res = t_res_i;
        end
        if (byte_valid_i)
        begin
            if (!have_high)
            begin
                next_high_byte = byte_i; // high byte arrives first
                next_have_high = 1'b1;
            end
            else
            begin
                next_have_high = 1'b0;
                word = {high_byte, byte_i} & conv_pkg::STATUS_MASK;
                if (!byte_is_temp_i)
                begin
                    next_rh_code = word;
                    next_have_rh = 1'b1;
                end
                else
                begin
                    next_have_rh = 1'b0;
                    // legacy divides by 2^res, native by 2^16
                    // same one-cycle latency in both protocols
                    sh = legacy_i ? t_res : 5'(conv_pkg::NATIVE_SHIFT);
                    next_result.t_centi = scale(word, conv_pkg::T_SCALE_CENTI,
                                                conv_pkg::T_OFFSET_CENTI, sh);
                    sh = legacy_i ? rh_res : 5'(conv_pkg::NATIVE_SHIFT);
                    next_result.rh_centi = scale(rh_code, conv_pkg::RH_SCALE_CENTI,
                                                 conv_pkg::RH_OFFSET_CENTI, sh);
                    if (over_ice_i)
                        next_result.rh_centi = ice_fix(next_result.rh_centi,
                                                       next_result.t_centi);
                    next_result_valid = have_rh;
                end
            end
        end
    end

    // registers; reset restores default resolutions
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            high_byte <= 8'h00;
            have_high <= 1'b0;
            rh_code <= 16'h0000;
            have_rh <= 1'b0;
            rh_res <= conv_pkg::RH_RES_DEFAULT;
            t_res <= conv_pkg::T_RES_DEFAULT;
            result <= '0;
            result_valid <= 1'b0;
        end
        else
        begin
            high_byte <= next_high_byte;
            have_high <= next_have_high;
            rh_code <= next_rh_code;
            have_rh <= next_have_rh;
            rh_res <= next_rh_res;
            t_res <= next_t_res;
            result <= next_result;
            result_valid <= next_result_valid;
        end
    end

    assign rh_res_o = rh_res;
    assign t_res_o = t_res;
    assign result_o = result;
    assign result_valid_o = result_valid;

    // checks; the reset check runs through reset, the rest wait it out
    a_reset_res: assert property (@(posedge core_clk_i) $past(rst_i) |->
        rh_res == conv_pkg::RH_RES_DEFAULT && t_res == conv_pkg::T_RES_DEFAULT)
        else $error("default resolution wrong");
    a_valid_once: assert property (@(posedge core_clk_i) disable iff (rst_i) result_valid |=> !result_valid)
        else $error("valid longer than a cycle");
    a_valid_cause: assert property (@(posedge core_clk_i) disable iff (rst_i)
        result_valid |-> $past(closes_temp(byte_valid_i, have_high, byte_is_temp_i)))
        else $error("valid without temperature low byte");
    a_pair_toggle: assert property (@(posedge core_clk_i) disable iff (rst_i)
        byte_valid_i |=> have_high != $past(have_high))
        else $error("byte pairing broken");
    a_rh_masked: assert property (@(posedge core_clk_i) disable iff (rst_i) rh_code[1:0] == 2'b00)
        else $error("status bits kept");
    // stored humidity word is the received pair with status bits cleared
    a_rh_store: assert property (@(posedge core_clk_i) disable iff (rst_i)
        byte_valid_i && have_high && !byte_is_temp_i
        |=> rh_code == ($past({high_byte, byte_i}) & conv_pkg::STATUS_MASK))
        else $error("humidity word not stored masked");
    a_zero_rh: assert property (@(posedge core_clk_i) disable iff (rst_i)
        result_valid && $past(rh_code) == 16'h0000 && !$past(over_ice_i)
        |-> result.rh_centi == 32'(conv_pkg::RH_OFFSET_CENTI))
        else $error("humidity offset wrong");
    a_zero_t: assert property (@(posedge core_clk_i) disable iff (rst_i)
        result_valid && $past({high_byte, byte_i}) < 16'h0004
        |-> result.t_centi == 32'(conv_pkg::T_OFFSET_CENTI))
        else $error("temperature offset wrong");
    a_res_load: assert property (@(posedge core_clk_i) disable iff (rst_i)
        res_load_i |=> rh_res == $past(rh_res_i) && t_res == $past(t_res_i))
        else $error("resolution load lost");
    // resolutions only move on a load; a stray change would skew legacy scaling
    a_res_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !res_load_i |=> $stable(rh_res) && $stable(t_res))
        else $error("resolution changed without load");
    // a temperature word with no humidity word before it gives no strobe
    a_lone_temp: assert property (@(posedge core_clk_i) disable iff (rst_i)
        closes_temp(byte_valid_i, have_high, byte_is_temp_i) && !have_rh |=> !result_valid)
        else $error("strobe without humidity word");
    // result only moves when a temperature word completes
    a_result_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !closes_temp(byte_valid_i, have_high, byte_is_temp_i) |=> $stable(result))
        else $error("result changed between words");
    c_result: cover property (@(posedge core_clk_i) result_valid);
    c_legacy: cover property (@(posedge core_clk_i) result_valid && $past(legacy_i));
    c_ice: cover property (@(posedge core_clk_i) result_valid && $past(over_ice_i));
    c_lone_temp: cover property (@(posedge core_clk_i)
        closes_temp(byte_valid_i, have_high, byte_is_temp_i) && !have_rh);
    c_res_load: cover property (@(posedge core_clk_i) res_load_i && legacy_i);
endmodule : humidity_temp_code_converter

// ---- core/conv_pkg.sv ----
package conv_pkg;
    // result framing
    localparam int BYTE_W = 8;
    localparam int WORD_W = 16;
    localparam logic [15:0] STATUS_MASK = 16'hfffc;
    // default resolutions after reset
    localparam logic [4:0] RH_RES_DEFAULT = 5'h0c;
    localparam logic [4:0] T_RES_DEFAULT = 5'h0e;
    // humidity: -6 + 125*s/2^16, hundredths: -600 + 12500*s/2^16
    localparam int RH_OFFSET_CENTI = -600;
    localparam int RH_SCALE_CENTI = 12500;
    // temperature: -46.85 + 175.72*s/2^16, hundredths
    localparam int T_OFFSET_CENTI = -4685;
    localparam int T_SCALE_CENTI = 17572;
    localparam int NATIVE_SHIFT = 16;
    // ice coefficients kept in hundredths
    localparam int BETA_W_CENTI = 1762;
    localparam int LAMBDA_W_CENTI = 24312;
    localparam int BETA_I_CENTI = 2246;
    localparam int LAMBDA_I_CENTI = 27262;

    typedef struct packed {
        logic [15:0] rh_code;
        logic [15:0] t_code;
        logic [4:0] rh_res;
        logic [4:0] t_res;
        logic legacy;
        logic over_ice;
    } conv_req_t;

    typedef struct packed {
        logic signed [31:0] rh_centi;
        logic signed [31:0] t_centi;
    } conv_res_t;
endpackage : conv_pkg

// ---- testbench/sensor_bytes_model.sv ----
`timescale 1ns/1ps
module sensor_bytes_model (
    input wire logic core_clk_i,
    output logic byte_valid_o,
    output logic [7:0] byte_o,
    output logic is_temp_o
);
    initial
    begin
        byte_valid_o = 1'b0;
        byte_o = 8'h00;
        is_temp_o = 1'b0;
    end
    // high byte first, then low byte
    task automatic send_word(input logic [15:0] w, input logic tmp);
        for (int i = 1; i >= 0; i--)
        begin
            @(negedge core_clk_i);
            byte_valid_o = 1'b1;
            byte_o = w[i*8 +: 8];
            is_temp_o = tmp;
        end
        @(negedge core_clk_i);
        byte_valid_o = 1'b0;
        byte_o = ~byte_o; // idle shows no stale data
    endtask : send_word
endmodule : sensor_bytes_model

// ---- testbench/humidity_temp_code_converter_tb.sv ----
`timescale 1ns/1ps
`define chk_eq(nm, e, g) begin tests_run++; if ((g) !== (e)) begin failures++; \
    $display("[ERR] %s exp %0d got %0d", nm, e, g); end end
module humidity_temp_code_converter_tb;
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic legacy_i = 1'b0;
    logic over_ice_i = 1'b0;
    logic res_load_i = 1'b0;
    logic [4:0] rh_res_i = 5'h0c;
    logic [4:0] t_res_i = 5'h0e;
    logic byte_valid, is_temp, result_valid_o;
    logic [7:0] byte_d;
    logic [4:0] rh_res_o, t_res_o;
    conv_pkg::conv_res_t result_o;
    int failures = 0;
    int tests_run = 0;
    int pulses = 0;
    always #2 core_clk_i = ~core_clk_i;
    sensor_bytes_model link (.core_clk_i(core_clk_i), .byte_valid_o(byte_valid), .byte_o(byte_d),
        .is_temp_o(is_temp));
    humidity_temp_code_converter DUT (.core_clk_i(core_clk_i), .rst_i(rst_i), .byte_valid_i(byte_valid),
        .byte_i(byte_d), .byte_is_temp_i(is_temp), .legacy_i(legacy_i), .over_ice_i(over_ice_i),
        .res_load_i(res_load_i), .rh_res_i(rh_res_i), .t_res_i(t_res_i), .rh_res_o(rh_res_o),
        .t_res_o(t_res_o), .result_o(result_o), .result_valid_o(result_valid_o));
    // strobes counted mid-cycle, where the registered pulse stands settled
    always @(negedge core_clk_i)
        if (result_valid_o === 1'b1) pulses++;
    // reference: mask, scale, round half up, add offset
    function automatic logic signed [31:0] conv(input logic [15:0] w, input longint sc, input longint of,
                                                input int sh);
        longint s;
        s = w & 16'hfffc;
        return 32'(of + ((s * sc + (64'sd1 <<< (sh - 1))) >>> sh));
    endfunction : conv
    task automatic pair(input logic [15:0] rw, input logic [15:0] tw, input int rsh, input int tsh);
        int p0;
        p0 = pulses;
        link.send_word(rw, 1'b0);
        link.send_word(tw, 1'b1);
        repeat (3) @(negedge core_clk_i);
        `chk_eq("pulse", p0 + 1, pulses)
        `chk_eq("rh", conv(rw, conv_pkg::RH_SCALE_CENTI, conv_pkg::RH_OFFSET_CENTI, rsh), result_o.rh_centi)
        `chk_eq("t", conv(tw, conv_pkg::T_SCALE_CENTI, conv_pkg::T_OFFSET_CENTI, tsh), result_o.t_centi)
    endtask : pair
    // ice reference in reals from the coefficients; design approximates exp, so 1% plus 3 counts
    task automatic ice_pair(input logic [15:0] rw, input logic [15:0] tw);
        real rh_w;
        real t_c;
        real rh_i;
        int e;
        int lim;
        int p0;
        rh_w = -6.0 + 125.0 * real'(rw & 16'hfffc) / 65536.0;
        t_c = -46.85 + 175.72 * real'(tw & 16'hfffc) / 65536.0;
        rh_i = rh_w * $exp(real'(conv_pkg::BETA_W_CENTI) / 100.0 * t_c / (real'(conv_pkg::LAMBDA_W_CENTI) / 100.0 + t_c))
            / $exp(real'(conv_pkg::BETA_I_CENTI) / 100.0 * t_c / (real'(conv_pkg::LAMBDA_I_CENTI) / 100.0 + t_c));
        e = int'(rh_i * 100.0);
        lim = (e < 0 ? -e : e) / 100 + 3;
        p0 = pulses;
        over_ice_i = 1'b1;
        link.send_word(rw, 1'b0);
        link.send_word(tw, 1'b1);
        repeat (3) @(negedge core_clk_i);
        over_ice_i = 1'b0;
        `chk_eq("ice_pulse", p0 + 1, pulses)
        `chk_eq("ice_rh", 1, (result_o.rh_centi - e <= lim) && (e - result_o.rh_centi <= lim))
    endtask : ice_pair
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop
    // hang guard, far beyond the few hundred cycles needed
    initial
    begin
        #20000;
        failures++;
        report_and_stop();
    end
    initial
    begin
        void'($urandom(49));
        repeat (6) @(negedge core_clk_i);
        rst_i = 1'b0;
        `chk_eq("rh_res", 5'h0c, rh_res_o)
        `chk_eq("t_res", 5'h0e, t_res_o)
        // temperature word alone must not strobe
        link.send_word(16'h6350, 1'b1);
        repeat (3) @(negedge core_clk_i);
        `chk_eq("lone_t", 0, pulses)
        pair(16'h6350, 16'h0003, 16, 16);
        pair(16'hffff, 16'hffff, 16, 16);
        pair(16'h0002, 16'h0001, 16, 16);
        ice_pair(16'h8000, 16'h35b0);
        ice_pair(16'h6350, 16'h68ac);
        for (int i = 0; i < 20; i++)
            pair(16'($urandom), 16'($urandom), 16, 16);
        legacy_i = 1'b1;
        for (int i = 0; i < 3; i++)
        begin
            rh_res_i = 5'(8 + 2 * i);
            t_res_i = 5'(12 + i);
            res_load_i = 1'b1; // only resolution bits change on a legacy write
            @(negedge core_clk_i);
            res_load_i = 1'b0;
            `chk_eq("rh_res_ld", 5'(8 + 2 * i), rh_res_o)
            `chk_eq("t_res_ld", 5'(12 + i), t_res_o)
            pair(16'($urandom % (1 << (8 + 2 * i))), 16'($urandom % (1 << (12 + i))), 8 + 2 * i, 12 + i);
        end
        // native divisor ignores the loaded resolution
        legacy_i = 1'b0;
        pair(16'($urandom), 16'($urandom), 16, 16);
        rst_i = 1'b1;
        repeat (2) @(negedge core_clk_i);
        rst_i = 1'b0;
        `chk_eq("rh_res_rst", 5'h0c, rh_res_o)
        `chk_eq("t_res_rst", 5'h0e, t_res_o)
        `chk_eq("res_rst", 64'h0, result_o)
        pair(16'h6350, 16'h6350, 16, 16);
        report_and_stop();
    end
endmodule : humidity_temp_code_converter_tb
